// file: inc/uls_pkg.sv
/*
 * Constants for the UART line status logic: register offsets, field
 * positions, reset values and receive/transmit storage depth.
 * Assumes a single clock domain and a plain strobe register port.
 */
package uls_pkg;

   // ************************************************************
   // Register offsets on the strobe port
   // ************************************************************
   localparam int         ADDR_W   = 3;                 // Address width
   localparam int         DATA_W   = 8;                 // Data width
   localparam logic [2:0] OFF_DATA = 3'h0;              // Rx pop on read, tx push on write
   localparam logic [2:0] OFF_CTRL = 3'h1;              // Mode and enable bits
   localparam logic [2:0] OFF_LSTAT = 3'h2;             // line_status, read-only
   localparam logic [2:0] OFF_EVT  = 3'h3;              // Sticky events, clear on read
   localparam logic [2:0] OFF_MASK = 3'h4;              // Event mask

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int CTRL_FIFO    = 0;                     // FIFO mode enable
   localparam int CTRL_THRE_IE = 1;                     // Holding-empty interrupt enable

   // ************************************************************
   // line_status fields and reset value
   // ************************************************************
   localparam int         LST_DR    = 0;                // Receive data ready
   localparam int         LST_OE    = 1;                // Overrun
   localparam int         LST_PE    = 2;                // Parity error at head
   localparam int         LST_FE    = 3;                // Framing error at head
   localparam int         LST_BI    = 4;                // Break at head
   localparam int         LST_THRE  = 5;                // Holding register / FIFO empty
   localparam int         LST_TEMT  = 6;                // Transmitter fully empty
   localparam int         LST_ERR   = 7;                // Any error in receive FIFO
   localparam logic [7:0] LST_RESET = 8'h60;            // Both transmit empties set

   // ************************************************************
   // Event status fields
   // ************************************************************
   localparam int EVT_W       = 5;                      // Number of event bits
   localparam int EVT_RXDATA  = 0;                      // Character stored
   localparam int EVT_OVERRUN = 1;                      // Character lost
   localparam int EVT_BREAK   = 2;                      // Break character stored
   localparam int EVT_RXERR   = 3;                      // Errored character stored
   localparam int EVT_TXEMPTY = 4;                      // Transmit store went empty

   // ************************************************************
   // Receive entry layout and storage depth
   // ************************************************************
   localparam int ENT_PE     = 8;                       // Parity flag position
   localparam int ENT_FE     = 9;                       // Framing flag position
   localparam int ENT_BI     = 10;                      // Break flag position
   localparam int ENT_W      = 11;                      // Entry width
   localparam int FIFO_DEPTH = 128;                     // Receive and transmit depth

endpackage

// file: rtl/uls_line_status.sv
/*
 * Line status logic of a single-channel UART: receive store with
 * per-character flags, transmit store, line_status word, events, irq.
 * Assumes the receiver and transmit shifter run on clk; rx_pin is async.
 */
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module uls_line_status
#(
   parameter int DEPTH = uls_pkg::FIFO_DEPTH           // Store depth, power of two
)
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [uls_pkg::ADDR_W-1:0]  addr,
   input  wire logic [uls_pkg::DATA_W-1:0]  wdata,
   input  wire logic                        wr_stb,
   input  wire logic                        rd_stb,
   output logic      [uls_pkg::DATA_W-1:0]  rdata,
   output logic                             irq,
   input  wire logic                        rx_pin,
   input  wire logic                        rx_done,
   input  wire logic [7:0]                  rx_char,
   input  wire logic                        rx_pe,
   input  wire logic                        rx_fe,
   input  wire logic                        rx_brk,
   input  wire logic                        tx_busy,
   input  wire logic                        tx_take,
   output logic      [7:0]                  tx_data,
   output logic                             tx_valid
);

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam int PW = $clog2(DEPTH);                   // Pointer width
   localparam int CW = PW + 1;                          // Count width
   localparam logic [CW-1:0] CAP_FIFO = CW'(DEPTH);     // Capacity in FIFO mode
   localparam logic [CW-1:0] CAP_ONE  = CW'(1);         // Capacity in plain mode

   logic [uls_pkg::ENT_W-1:0] rx_mem [DEPTH];           // Receive entries
   logic [7:0]                tx_mem [DEPTH];           // Transmit bytes
   logic            rx_meta_r, rx_sync_r;               // Line synchroniser
   logic [PW-1:0]   rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
   logic [CW-1:0]   rx_cnt_r, rx_cnt_nxt;               // Receive fill
   logic [CW-1:0]   err_cnt_r, err_cnt_nxt;             // Errored entries held
   logic [PW-1:0]   tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
   logic [CW-1:0]   tx_cnt_r, tx_cnt_nxt;               // Transmit fill
   logic            fifo_en_r, fifo_en_nxt;             // FIFO mode
   logic            thre_ie_r, thre_ie_nxt;             // Holding-empty irq enable
   logic            brk_hold_r, brk_hold_nxt;           // Break already stored
   logic [7:0]      lst_r, lst_nxt;                     // line_status_word
   logic [uls_pkg::EVT_W-1:0] evt_r, evt_nxt;           // Sticky events
   logic [uls_pkg::EVT_W-1:0] mask_r, mask_nxt;         // Event mask
   logic            irq_r, irq_nxt;
   logic [7:0]      rdata_r, rdata_nxt;
   logic [7:0]      tx_data_r, tx_data_nxt;
   logic            tx_valid_r, tx_valid_nxt;

   logic            wr_data, rd_data, rd_lst, rd_evt, mode_chg;
   logic [CW-1:0]   cap;                                // Current capacity
   logic            rx_push, rx_pop, rx_ovr, brk_drop, new_err, head_err;
   logic            tx_push, tx_pop;
   logic [uls_pkg::ENT_W-1:0] new_ent, head_ent;        // Incoming and next head
   logic [uls_pkg::EVT_W-1:0] ev;                       // Events this cycle

   // ************************************************************
   // Receive line synchroniser
   // ************************************************************
   // Two flops before the break-release logic sees the line
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end
      else
      begin
         rx_meta_r <= rx_pin;
         rx_sync_r <= rx_meta_r;
      end
   end

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb
   begin
      // Bus decode
      wr_data  = wr_stb && (addr == uls_pkg::OFF_DATA);
      rd_data  = rd_stb && (addr == uls_pkg::OFF_DATA);
      rd_lst   = rd_stb && (addr == uls_pkg::OFF_LSTAT);
      rd_evt   = rd_stb && (addr == uls_pkg::OFF_EVT);
      mode_chg = wr_stb && (addr == uls_pkg::OFF_CTRL)
                 && (wdata[uls_pkg::CTRL_FIFO] != fifo_en_r);
      cap      = fifo_en_r ? CAP_FIFO : CAP_ONE;

      // Control and mask writes; line_status offset takes no write
      // status word read-only
      fifo_en_nxt = fifo_en_r;
      thre_ie_nxt = thre_ie_r;
      mask_nxt    = mask_r;
      if (wr_stb && (addr == uls_pkg::OFF_CTRL))
      begin
         fifo_en_nxt = wdata[uls_pkg::CTRL_FIFO];
         thre_ie_nxt = wdata[uls_pkg::CTRL_THRE_IE];
      end
      if (wr_stb && (addr == uls_pkg::OFF_MASK))
         mask_nxt = wdata[uls_pkg::EVT_W-1:0];

      new_ent  = {rx_brk, rx_fe, rx_pe, rx_char};
      new_err  = rx_pe || rx_fe || rx_brk;
      head_err = |rx_mem[rx_rp_r][uls_pkg::ENT_BI:uls_pkg::ENT_PE];
      brk_drop = rx_brk && brk_hold_r && fifo_en_r;
      rx_pop   = rd_data && (rx_cnt_r != '0);
      rx_ovr   = rx_done && !brk_drop && (rx_cnt_r >= cap);
      rx_push  = rx_done && !brk_drop && (rx_cnt_r < cap);

      // Break hold clears once the line has returned high
      brk_hold_nxt = brk_hold_r;
      if (rx_push && rx_brk)
         brk_hold_nxt = 1'b1;
      else if (rx_sync_r)
         brk_hold_nxt = 1'b0;

      rx_wp_nxt   = rx_push ? rx_wp_r + PW'(1) : rx_wp_r;
      rx_rp_nxt   = rx_pop ? rx_rp_r + PW'(1) : rx_rp_r;
      rx_cnt_nxt  = rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
      err_cnt_nxt = err_cnt_r + CW'(rx_push && new_err) - CW'(rx_pop && head_err);

      // Transmit store; capacity one is the holding register
      tx_pop     = tx_take && (tx_cnt_r != '0);
      // A write beside a take refills the place freed by the take
      tx_push    = wr_data && ((tx_cnt_r < cap) || tx_pop);
      tx_wp_nxt  = tx_push ? tx_wp_r + PW'(1) : tx_wp_r;
      tx_rp_nxt  = tx_pop ? tx_rp_r + PW'(1) : tx_rp_r;
      tx_cnt_nxt = tx_cnt_r + CW'(tx_push) - CW'(tx_pop);

      // Mode change flushes both stores
      if (mode_chg)
      begin
         rx_wp_nxt    = '0;
         rx_rp_nxt    = '0;
         rx_cnt_nxt   = '0;
         err_cnt_nxt  = '0;
         tx_wp_nxt    = '0;
         tx_rp_nxt    = '0;
         tx_cnt_nxt   = '0;
         brk_hold_nxt = 1'b0;
      end

      // Head entry after this edge; a push into an emptied store is the head
      if (rx_cnt_nxt == '0)
         head_ent = '0;
      else if (rx_cnt_r == CW'(rx_pop))
         head_ent = new_ent;
      else
         head_ent = rx_mem[rx_rp_nxt];

      // Transmit head presented to the shifter
      tx_valid_nxt = (tx_cnt_nxt != '0);
      if (tx_cnt_nxt == '0)
         tx_data_nxt = 8'h00;
      else if (tx_cnt_r == CW'(tx_pop))
         tx_data_nxt = wdata;
      else
         tx_data_nxt = tx_mem[tx_rp_nxt];

      // data ready while store holds data
      lst_nxt[uls_pkg::LST_DR]   = (rx_cnt_nxt != '0);
      // sticky overrun, set wins over read clear
      lst_nxt[uls_pkg::LST_OE]   = (lst_r[uls_pkg::LST_OE] && !rd_lst) || rx_ovr;
      lst_nxt[uls_pkg::LST_PE]   = head_ent[uls_pkg::ENT_PE];
      lst_nxt[uls_pkg::LST_FE]   = head_ent[uls_pkg::ENT_FE];
      lst_nxt[uls_pkg::LST_BI]   = head_ent[uls_pkg::ENT_BI];
      lst_nxt[uls_pkg::LST_THRE] = (tx_cnt_nxt == '0);
      lst_nxt[uls_pkg::LST_TEMT] = (tx_cnt_nxt == '0) && !tx_busy && !tx_pop;
      lst_nxt[uls_pkg::LST_ERR]  = (err_cnt_nxt != '0);

      // Events; a new event wins over the read clear
      ev = '0;
      ev[uls_pkg::EVT_RXDATA]  = rx_push;
      ev[uls_pkg::EVT_OVERRUN] = rx_ovr;
      ev[uls_pkg::EVT_BREAK]   = rx_push && rx_brk;
      ev[uls_pkg::EVT_RXERR]   = rx_push && new_err;
      ev[uls_pkg::EVT_TXEMPTY] = lst_nxt[uls_pkg::LST_THRE] && !lst_r[uls_pkg::LST_THRE];
      evt_nxt = (rd_evt ? '0 : evt_r) | ev;

      irq_nxt = (|(evt_r & mask_r)) || (lst_r[uls_pkg::LST_THRE] && thre_ie_r);

      // Read data, present only in the cycle after the strobe
      rdata_nxt = 8'h00;
      if (rd_stb)
      begin
         case (addr)
            uls_pkg::OFF_DATA: rdata_nxt = (rx_cnt_r != '0) ? rx_mem[rx_rp_r][7:0] : 8'h00;
            uls_pkg::OFF_CTRL: rdata_nxt = {6'h00, thre_ie_r, fifo_en_r};
            uls_pkg::OFF_LSTAT: rdata_nxt = lst_r;
            uls_pkg::OFF_EVT:  rdata_nxt = {3'h0, evt_r};
            uls_pkg::OFF_MASK: rdata_nxt = {3'h0, mask_r};
            default:           rdata_nxt = 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Storage arrays, no reset needed
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (rx_push)
         rx_mem[rx_wp_r] <= new_ent;
      if (tx_push)
         tx_mem[tx_wp_r] <= wdata;
   end

   // ************************************************************
   // State registers
   // ************************************************************
   // empty defaults after reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_wp_r    <= '0;
         rx_rp_r    <= '0;
         rx_cnt_r   <= '0;
         err_cnt_r  <= '0;
         tx_wp_r    <= '0;
         tx_rp_r    <= '0;
         tx_cnt_r   <= '0;
         fifo_en_r  <= 1'b0;
         thre_ie_r  <= 1'b0;
         brk_hold_r <= 1'b0;
         lst_r      <= uls_pkg::LST_RESET;
         evt_r      <= '0;
         mask_r     <= '0;
         irq_r      <= 1'b0;
         rdata_r    <= 8'h00;
         tx_data_r  <= 8'h00;
         tx_valid_r <= 1'b0;
      end
      else
      begin
         rx_wp_r    <= rx_wp_nxt;
         rx_rp_r    <= rx_rp_nxt;
         rx_cnt_r   <= rx_cnt_nxt;
         err_cnt_r  <= err_cnt_nxt;
         tx_wp_r    <= tx_wp_nxt;
         tx_rp_r    <= tx_rp_nxt;
         tx_cnt_r   <= tx_cnt_nxt;
         fifo_en_r  <= fifo_en_nxt;
         thre_ie_r  <= thre_ie_nxt;
         brk_hold_r <= brk_hold_nxt;
         lst_r      <= lst_nxt;
         evt_r      <= evt_nxt;
         mask_r     <= mask_nxt;
         irq_r      <= irq_nxt;
         rdata_r    <= rdata_nxt;
         tx_data_r  <= tx_data_nxt;
         tx_valid_r <= tx_valid_nxt;
      end
   end

   assign rdata    = rdata_r;
   assign irq      = irq_r;
   assign tx_data  = tx_data_r;
   assign tx_valid = tx_valid_r;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_err_set: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_push && new_err && !mode_chg) |=> lst_r[uls_pkg::LST_ERR])
      else $error("error summary not set");
   a_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_cnt_nxt == '0) |=> !lst_r[uls_pkg::LST_ERR])
      else $error("error summary not cleared");
   a_temt_busy: assert property (@(posedge clk) disable iff (!rst_n)
      (!fifo_en_r && tx_busy) |=> !lst_r[uls_pkg::LST_TEMT])
      else $error("transmit empty while shifter busy");
   a_temt_fifo: assert property (@(posedge clk) disable iff (!rst_n)
      (fifo_en_r && tx_cnt_r == '0 && !wr_stb && !tx_busy && !mode_chg)
      |=> lst_r[uls_pkg::LST_TEMT])
      else $error("transmit empty not shown");
   a_thre_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_data && !mode_chg) |=> !lst_r[uls_pkg::LST_THRE] && tx_valid_r)
      else $error("holding empty not cleared by write");
   a_thre_set: assert property (@(posedge clk) disable iff (!rst_n)
      (tx_take && tx_cnt_r == CAP_ONE && !wr_stb) |=> lst_r[uls_pkg::LST_THRE])
      else $error("holding empty not set after take");
   a_irq_thre: assert property (@(posedge clk) disable iff (!rst_n)
      (lst_r[uls_pkg::LST_THRE] && thre_ie_r) |=> irq_r)
      else $error("holding empty interrupt missing");
   a_break_head: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_done && rx_brk && !brk_hold_r && rx_cnt_r == '0 && !mode_chg)
      |=> lst_r[uls_pkg::LST_BI] && lst_r[uls_pkg::LST_ERR])
      else $error("break not flagged");
   a_break_once: assert property (@(posedge clk) disable iff (!rst_n)
      (brk_drop && !rx_pop && !mode_chg) |=> (rx_cnt_r == $past(rx_cnt_r)))
      else $error("second break character stored");
   a_frame_head: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_done && rx_fe && !brk_drop && rx_cnt_r == '0 && !mode_chg)
      |=> lst_r[uls_pkg::LST_FE])
      else $error("framing error not flagged");
   a_overrun: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_ovr && !rx_pop && !mode_chg)
      |=> lst_r[uls_pkg::LST_OE] && (rx_cnt_r == $past(rx_cnt_r)))
      else $error("overrun not flagged or store changed");
   a_data_ready: assert property (@(posedge clk) disable iff (!rst_n)
      (rx_push && !mode_chg) |=> lst_r[uls_pkg::LST_DR] && (rx_cnt_r != '0))
      else $error("data ready not set");

endmodule // uls_line_status

// file: verif/uls_far_model.sv
/*
 * Far-side model: receiver front end and transmit shifter of the UART.
 * Assumes the block's clock; the bench commands characters, line and stalls.
 */
`timescale 1ns/10ps
module uls_far_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            rx_pin,
   output logic            rx_done,
   output logic      [7:0] rx_char,
   output logic            rx_pe,
   output logic            rx_fe,
   output logic            rx_brk,
   output logic            tx_busy,
   output logic            tx_take
);
   logic       ready;      // Shifter accepts a byte when high
   int         hold;       // Shift time in cycles
   int         cnt;        // Remaining shift cycles
   logic [7:0] sent[$];    // Bytes taken by the shifter

   // Idle line high, nothing pending
   initial
   begin
      rx_pin = 1'b1;
      rx_done = 1'b0;
      rx_char = 8'h00;
      rx_pe = 1'b0;
      rx_fe = 1'b0;
      rx_brk = 1'b0;
      tx_busy = 1'b0;
      tx_take = 1'b0;
      ready = 1'b1;
      hold = 20;
      cnt = 0;
   end

   // Shifter: takes the head byte with busy already high, then shifts
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_take <= 1'b0;
         tx_busy <= 1'b0;
         cnt <= 0;
      end
      else if (tx_take)
      begin
         tx_take <= 1'b0;
         sent.push_back(tx_data);
      end
      else if (cnt > 0)
      begin
         cnt <= cnt - 1;
         tx_busy <= (cnt > 1);
      end
      else if (tx_valid && ready)
      begin
         tx_take <= 1'b1;
         tx_busy <= 1'b1;
         cnt <= hold;
      end
   end

   // One completed character; flags travel with it, then data shows junk
   task automatic send(input logic [7:0] c, input logic pe, input logic fe, input logic brk);
      @(posedge clk);
      rx_done <= 1'b1;
      rx_char <= c;
      rx_pe <= pe;
      rx_fe <= fe;
      rx_brk <= brk;
      @(posedge clk);
      rx_done <= 1'b0;
      rx_char <= ~c;
      rx_pe <= ~pe;
      rx_fe <= ~fe;
      rx_brk <= ~brk;
   endtask
endmodule // uls_far_model

// file: verif/uls_line_status_test.sv
/*
 * Self-checking bench for the line status logic: register port, tx, rx.
 * Assumes the far-side model and a store depth of 4.
 */
`timescale 1ns/10ps
module uls_line_status_test;
   logic       clk, rst_n, wr_stb, rd_stb, irq;       // Clock, reset, strobes
   logic [2:0] addr;                                  // Register offset
   logic [7:0] wdata, rdata, rx_char, tx_data, d;     // Data paths
   logic       rx_pin, rx_done, rx_pe, rx_fe, rx_brk; // Receiver side
   logic       tx_busy, tx_take, tx_valid;            // Transmit side
   int         n_mismatch;                            // Mismatches seen
   int         cmp_count;                             // Comparisons made
   int         k;                                     // Loop index

   uls_line_status #(.DEPTH(4)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .rx_pin(rx_pin),
      .rx_done(rx_done), .rx_char(rx_char), .rx_pe(rx_pe), .rx_fe(rx_fe), .rx_brk(rx_brk),
      .tx_busy(tx_busy), .tx_take(tx_take), .tx_data(tx_data), .tx_valid(tx_valid));
   uls_far_model i_far (.clk(clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
      .rx_pin(rx_pin), .rx_done(rx_done), .rx_char(rx_char), .rx_pe(rx_pe), .rx_fe(rx_fe),
      .rx_brk(rx_brk), .tx_busy(tx_busy), .tx_take(tx_take));

   // ************************************************************
   // Clock, watchdog, bus and compare helpers
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Cuts a hang short well beyond the expected run
   initial
   begin
      #200000;
      n_mismatch++;
      end_sim();
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
      chk8(d, exp);
   endtask

   // Bounded wait until the shifter has taken everything and gone idle
   task automatic wait_tx;
      for (int i = 0; i < 200 && (tx_valid !== 1'b0 || tx_busy !== 1'b0); i++)
         @(posedge clk);
      cyc(2);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      chk8(rdata, 8'h00);
      chk1(irq, 1'b0);
      rdc(uls_pkg::OFF_LSTAT, 8'h60);
      wr(uls_pkg::OFF_LSTAT, 8'h1f);
      rdc(uls_pkg::OFF_LSTAT, 8'h60);
      rdc(3'h5, 8'h00);
   endtask

   task automatic t_tx_single;
      i_far.ready <= 1'b0;
      wr(uls_pkg::OFF_DATA, 8'h96);
      rdc(uls_pkg::OFF_LSTAT, 8'h00);
      chk1(tx_valid, 1'b1);
      i_far.ready <= 1'b1;
      for (int i = 0; i < 20 && tx_busy !== 1'b1; i++)
         @(posedge clk);
      rdc(uls_pkg::OFF_LSTAT, 8'h20);
      wait_tx();
      rdc(uls_pkg::OFF_LSTAT, 8'h60);
      chk1(tx_valid, 1'b0);
      chk8(i_far.sent.pop_front(), 8'h96);
   endtask

   task automatic t_tx_fifo;
      wr(uls_pkg::OFF_CTRL, 8'h01);
      i_far.ready <= 1'b0;
      for (k = 0; k < 3; k++)
         wr(uls_pkg::OFF_DATA, 8'ha0 + k[7:0]);
      rdc(uls_pkg::OFF_LSTAT, 8'h00);
      i_far.ready <= 1'b1;
      wait_tx();
      rdc(uls_pkg::OFF_LSTAT, 8'h60);
      for (k = 0; k < 3; k++)
         chk8(i_far.sent.pop_front(), 8'ha0 + k[7:0]);
   endtask

   task automatic t_irq;
      wr(uls_pkg::OFF_CTRL, 8'h03);
      cyc(3);
      chk1(irq, 1'b1);
      i_far.ready <= 1'b0;
      wr(uls_pkg::OFF_DATA, 8'h5c);
      cyc(2);
      chk1(irq, 1'b0);
      i_far.ready <= 1'b1;
      wait_tx();
      chk1(irq, 1'b1);
      i_far.sent.delete();
      wr(uls_pkg::OFF_CTRL, 8'h01);
      rdc(uls_pkg::OFF_EVT, 8'h10);
      wr(uls_pkg::OFF_MASK, 8'h01);
      i_far.send(8'h77, 1'b0, 1'b0, 1'b0);
      cyc(3);
      chk1(irq, 1'b1);
      rdc(uls_pkg::OFF_EVT, 8'h01);
      cyc(2);
      chk1(irq, 1'b0);
      rdc(uls_pkg::OFF_DATA, 8'h77);
      wr(uls_pkg::OFF_MASK, 8'h00);
      i_far.send(8'h78, 1'b0, 1'b0, 1'b0);
      cyc(3);
      chk1(irq, 1'b0);
      rdc(uls_pkg::OFF_DATA, 8'h78);
   endtask

   task automatic t_rx_single;
      wr(uls_pkg::OFF_CTRL, 8'h00);
      i_far.send(8'h5a, 1'b1, 1'b0, 1'b0);
      rdc(uls_pkg::OFF_LSTAT, 8'he5);
      rdc(uls_pkg::OFF_DATA, 8'h5a);
      rdc(uls_pkg::OFF_LSTAT, 8'h60);
      i_far.send(8'h11, 1'b0, 1'b0, 1'b0);
      i_far.send(8'h22, 1'b0, 1'b0, 1'b0);
      rdc(uls_pkg::OFF_LSTAT, 8'h63);
      rdc(uls_pkg::OFF_LSTAT, 8'h61);
      rdc(uls_pkg::OFF_DATA, 8'h11);
   endtask

   // Four entries fill the store exactly unless the repeated break is kept
   task automatic t_rx_fifo;
      wr(uls_pkg::OFF_CTRL, 8'h01);
      i_far.send(8'h31, 1'b0, 1'b0, 1'b0);
      i_far.send(8'h32, 1'b0, 1'b1, 1'b0);
      i_far.rx_pin <= 1'b0;
      i_far.send(8'h00, 1'b0, 1'b1, 1'b1);
      i_far.send(8'h00, 1'b0, 1'b1, 1'b1);
      i_far.rx_pin <= 1'b1;
      cyc(5);
      i_far.send(8'h33, 1'b0, 1'b0, 1'b0);
      rdc(uls_pkg::OFF_LSTAT, 8'he1);
      rdc(uls_pkg::OFF_DATA, 8'h31);
      rdc(uls_pkg::OFF_LSTAT, 8'he9);
      rdc(uls_pkg::OFF_DATA, 8'h32);
      rdc(uls_pkg::OFF_LSTAT, 8'hf9);
      rdc(uls_pkg::OFF_DATA, 8'h00);
      rdc(uls_pkg::OFF_LSTAT, 8'h61);
      rdc(uls_pkg::OFF_DATA, 8'h33);
      rdc(uls_pkg::OFF_LSTAT, 8'h60);
      rdc(uls_pkg::OFF_DATA, 8'h00);
   endtask

   // ************************************************************
   // Main sequence and verdict
   // ************************************************************
   task automatic end_sim;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      rst_n = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      t_reset();
      t_tx_single();
      t_tx_fifo();
      t_irq();
      t_rx_single();
      t_rx_fifo();
      end_sim();
   end
endmodule // uls_line_status_test
